// file: shared/pios_cfg.svh
// constants, register codes and timing counts for the port and serial shift block
// Operation
// - port C direction bit clear makes pin output, set makes it input.
// - port D direction bit clear makes pin output, set makes it input.
// - reset puts both bidirectional ports in input mode, direction all ones.
// - output pins of ports C and D always drive push-pull.
// - enabled port C level change raises interrupt or hold release.
// - write-only change enable gates each port C pin's change event.
// - change status bit n sets on pin n change; read and clear by instruction.
// - interrupt accept clears only event bit; status kept until clear, enable write, reset.
// - falling edge on stop-wake enabled port C pin leaves stop mode.
// - with mode bit clear, output port drives the internal parallel latch.
// - serial mode pins: data out, tx clock, data in, rx clock; data in pulled up.
// - receive instruction returns old rx buffer, then sets rx busy at status bit 1.
// - eight rx clock pulses; data in sampled on each rising edge.
// - after eighth rx clock clear busy, set event 5, interrupt or release hold.
// - transmit loads buffer, sets busy bit 3, eight clocks, data changes on falling edge.
// - after eighth tx clock clear busy, set event 6, interrupt or release hold.
// - shift byte low nibble is accumulator, high nibble is RAM register.
// - busy status: rx busy bit 1, tx busy bit 3, bits 0 and 2 reserved.
// - output port mode bit 1 selects latch output or serial operation.
// - output port mode bit 3 selects shift rate Fosc/2 or Fosc/256.
`ifndef PIOS_CFG_SVH
`define PIOS_CFG_SVH

`define PIOS_NIB_W 4
`define PIOS_BYTE_W 8
`define PIOS_DIR_RESET 4'hF
`define PIOS_NIB_ZERO 4'h0
`define PIOS_MODE_SERIAL_BIT 1
`define PIOS_MODE_RATE_BIT 3
`define PIOS_BUSY_RX_BIT 1
`define PIOS_BUSY_TX_BIT 3
`define PIOS_EVT_CHANGE 2
`define PIOS_EVT_RX 5
`define PIOS_EVT_TX 6
`define PIOS_EVT_W 8
`define PIOS_PIN_DOUT 0
`define PIOS_PIN_TXCLK 1
`define PIOS_PIN_DIN 2
`define PIOS_PIN_RXCLK 3
`define PIOS_BITS_PER_BYTE 4'h8
`define PIOS_DIV_FAST 2
`define PIOS_DIV_SLOW 256
// half period terminal counts; each half period lasts the count plus one clock cycle
`define PIOS_HALF_FAST 8'h00
`define PIOS_HALF_SLOW 8'h7F

`endif

// file: shared/pios_pkg.sv
// types shared by the port and serial shift block
package pios_pkg;
    typedef enum logic [1:0] {PIOS_IDLE, PIOS_LOW, PIOS_HIGH} pios_phase_t;
endpackage

// file: hw/pios_shifter.sv
// one eight-bit serial shifter with its own clock pin, used for both directions
`timescale 1ns/1ps
`default_nettype none
`include "pios_cfg.svh"
module pios_shifter
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_start,
    input wire logic i_slow,
    input wire logic i_is_tx,
    input wire logic [7:0] i_load,
    input wire logic i_din,
    // status
    output logic o_busy,
    output logic o_done,
    output logic o_sclk,
    output logic o_dout,
    output logic [7:0] o_data
);
    pios_pkg::pios_phase_t phase_ff, nxt_phase;
    logic [7:0] div_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff;
    logic dout_ff;
    logic done_ff;
    wire [7:0] half_w = i_slow ? `PIOS_HALF_SLOW : `PIOS_HALF_FAST;
    wire tick_w = (div_ff == half_w);
    wire last_w = (cnt_ff == `PIOS_BITS_PER_BYTE);
    wire rise_w = (phase_ff == pios_pkg::PIOS_HIGH) && (div_ff == 8'h00);

    always_comb
    begin
        nxt_phase = phase_ff;
        case (phase_ff)
            pios_pkg::PIOS_IDLE: if (i_start) nxt_phase = pios_pkg::PIOS_LOW;
            pios_pkg::PIOS_LOW: if (tick_w) nxt_phase = pios_pkg::PIOS_HIGH;
            pios_pkg::PIOS_HIGH: if (tick_w) nxt_phase = last_w ? pios_pkg::PIOS_IDLE : pios_pkg::PIOS_LOW;
            default: nxt_phase = pios_pkg::PIOS_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_ff <= pios_pkg::PIOS_IDLE;
            div_ff <= 8'h00;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            dout_ff <= 1'b1;
            done_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            phase_ff <= nxt_phase;
            done_ff <= (phase_ff == pios_pkg::PIOS_HIGH) && tick_w && last_w;
            div_ff <= (phase_ff == pios_pkg::PIOS_IDLE || tick_w) ? 8'h00 : div_ff + 8'h01;
            if (phase_ff == pios_pkg::PIOS_IDLE && i_start)
            begin
                cnt_ff <= 4'h1;
                if (i_is_tx)
                begin
                    // first bit leaves on the first falling edge
                    dout_ff <= i_load[0];
                    sh_ff <= {1'b0, i_load[7:1]};
                end
            end
            else
            begin
                // the pin is registered a cycle behind the phase, so sample as the pin itself rises
                if (rise_w && !i_is_tx)
                    sh_ff <= {i_din, sh_ff[7:1]};
                if (phase_ff == pios_pkg::PIOS_HIGH && tick_w && !last_w)
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (i_is_tx)
                    begin
                        dout_ff <= sh_ff[0];
                        sh_ff <= {1'b0, sh_ff[7:1]};
                    end
                end
            end
        end
    end

    assign o_busy = (phase_ff != pios_pkg::PIOS_IDLE);
    assign o_done = done_ff;
    assign o_sclk = (phase_ff != pios_pkg::PIOS_LOW);
    assign o_dout = dout_ff;
    assign o_data = sh_ff;
endmodule // pios_shifter
`default_nettype wire

// file: hw/pios_top.sv
// ports C and D, change detect, output port latch and serial shifter
`timescale 1ns/1ps
`default_nettype none
`include "pios_cfg.svh"
module pios_top
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // instruction strobes
    input wire logic i_wr_port_c_direction,
    input wire logic i_wr_port_d_direction,
    input wire logic i_wr_change_detect_enable,
    input wire logic i_wr_output_port_mode,
    input wire logic i_wr_stop_wake_enable,
    input wire logic i_wr_port_c_data,
    input wire logic i_wr_port_d_data,
    input wire logic i_wr_parallel_latch,
    input wire logic i_clear_change_status_instr,
    input wire logic i_clear_busy_status,
    input wire logic i_receive_instruction,
    input wire logic i_transmit_instruction,
    input wire logic [3:0] i_wdata,
    input wire logic [3:0] i_accumulator,
    // event controller side
    input wire logic i_change_int_accept,
    // pins
    input wire logic [3:0] i_port_c,
    input wire logic [3:0] i_port_d,
    input wire logic i_serial_din,
    output logic [3:0] o_port_c,
    output logic [3:0] o_port_c_oe,
    output logic [3:0] o_port_d,
    output logic [3:0] o_port_d_oe,
    output logic [3:0] o_led_output_port,
    output logic o_serial_din_pullup,
    // read back
    output logic [3:0] o_port_c_in,
    output logic [3:0] o_port_d_in,
    output logic [3:0] o_change_detect_status,
    output logic [3:0] o_serial_busy_status,
    output logic [3:0] o_rx_accumulator,
    output logic [3:0] o_rx_ram,
    // events
    output logic [7:0] o_event_flags,
    output logic o_stop_wake
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] port_c_direction_ff, port_d_direction_ff;
    logic [3:0] change_detect_enable_ff, stop_wake_enable_ff;
    logic [3:0] output_port_mode_ff, internal_parallel_latch_ff;
    logic [3:0] port_c_out_ff, port_d_out_ff, port_c_prev_ff;
    logic [3:0] change_detect_status_ff, port_c_in_ff, port_d_in_ff;
    logic [3:0] port_c_pin_ff;
    logic [3:0] port_c_oe_ff;
    logic [3:0] port_d_pin_ff;
    logic [3:0] port_d_oe_ff;
    logic [3:0] led_ff;
    logic [3:0] rx_acc_ff, rx_ram_ff;
    logic rx_busy_flag_ff;
    logic tx_busy_flag_ff;
    logic change_evt_ff;
    logic stop_wake_ff;
    logic pullup_ff;
    logic [7:0] event_flags_ff;
    logic [7:0] rx_shift_buffer;
    logic rx_busy_w;
    logic rx_done_w;
    logic rx_clk_w;
    logic tx_busy_w;
    logic tx_done_w;
    logic tx_clk_w;
    logic tx_dout_w;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire serial_mode_w = output_port_mode_ff[`PIOS_MODE_SERIAL_BIT];
    wire slow_w = output_port_mode_ff[`PIOS_MODE_RATE_BIT];
    // pin level seen by the change logic: driven value for outputs
    wire [3:0] c_level_w = (port_c_direction_ff & i_port_c) | (~port_c_direction_ff & port_c_out_ff);
    wire [3:0] c_change_w = c_level_w ^ port_c_prev_ff;
    wire [3:0] c_fall_w = port_c_prev_ff & ~c_level_w;
    wire c_event_w = |(c_change_w & change_detect_enable_ff);
    wire rx_start_w = i_receive_instruction && serial_mode_w;
    wire tx_start_w = i_transmit_instruction && serial_mode_w;
    wire [3:0] led_w = serial_mode_w ?
        {rx_clk_w, 1'b1, tx_clk_w, tx_dout_w} : internal_parallel_latch_ff;
    wire [3:0] busy_w = {tx_busy_flag_ff, 1'b0, rx_busy_flag_ff, 1'b0};
    wire [3:0] d_level_w = (port_d_direction_ff & i_port_d) | (~port_d_direction_ff & port_d_out_ff);
    wire [3:0] c_oe_w = ~port_c_direction_ff;
    wire [3:0] d_oe_w = ~port_d_direction_ff;
    wire [7:0] event_w = {1'b0, tx_done_w, rx_done_w, 2'b00, change_evt_ff, 2'b00};
    wire [3:0] nxt_status = i_wr_change_detect_enable || i_clear_change_status_instr ?
        `PIOS_NIB_ZERO : change_detect_status_ff;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            port_c_direction_ff <= `PIOS_DIR_RESET;
            port_d_direction_ff <= `PIOS_DIR_RESET;
            change_detect_enable_ff <= `PIOS_NIB_ZERO;
            stop_wake_enable_ff <= `PIOS_NIB_ZERO;
            output_port_mode_ff <= `PIOS_NIB_ZERO;
            internal_parallel_latch_ff <= `PIOS_NIB_ZERO;
            port_c_out_ff <= `PIOS_NIB_ZERO;
            port_d_out_ff <= `PIOS_NIB_ZERO;
        end
        else if (i_ce)
        begin
            if (i_wr_port_c_direction)
                port_c_direction_ff <= i_wdata;
            if (i_wr_port_d_direction)
                port_d_direction_ff <= i_wdata;
            if (i_wr_change_detect_enable)
                change_detect_enable_ff <= i_wdata;
            if (i_wr_stop_wake_enable)
                stop_wake_enable_ff <= i_wdata;
            if (i_wr_output_port_mode)
                output_port_mode_ff <= i_wdata;
            if (i_wr_parallel_latch)
                internal_parallel_latch_ff <= i_wdata;
            if (i_wr_port_c_data)
                port_c_out_ff <= i_wdata;
            if (i_wr_port_d_data)
                port_d_out_ff <= i_wdata;
        end
    end

    // ------------------------------------------------------------
    // change detection and events
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            port_c_prev_ff <= `PIOS_NIB_ZERO;
            change_detect_status_ff <= `PIOS_NIB_ZERO;
            change_evt_ff <= 1'b0;
            stop_wake_ff <= 1'b0;
            rx_busy_flag_ff <= 1'b0;
            tx_busy_flag_ff <= 1'b0;
            rx_acc_ff <= `PIOS_NIB_ZERO;
            rx_ram_ff <= `PIOS_NIB_ZERO;
        end
        else if (i_ce)
        begin
            port_c_prev_ff <= c_level_w;
            // a change in the clearing cycle still lands
            change_detect_status_ff <= nxt_status | c_change_w;
            // accept clears the event only; set wins
            change_evt_ff <= c_event_w || (change_evt_ff && !i_change_int_accept);
            stop_wake_ff <= |(c_fall_w & stop_wake_enable_ff);
            if (rx_start_w)
            begin
                rx_acc_ff <= rx_shift_buffer[3:0];
                rx_ram_ff <= rx_shift_buffer[7:4];
            end
            // clear drops the flags only; a running engine still finishes its byte
            rx_busy_flag_ff <= rx_start_w
                || (rx_busy_flag_ff && !rx_done_w && !i_clear_busy_status);
            tx_busy_flag_ff <= tx_start_w
                || (tx_busy_flag_ff && !tx_done_w && !i_clear_busy_status);
        end
    end

    // ------------------------------------------------------------
    // serial engines
    // ------------------------------------------------------------
    pios_shifter u_rx
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_start(rx_start_w && !rx_busy_w),
        .i_slow(slow_w),
        .i_is_tx(1'b0),
        .i_load(8'h00),
        .i_din(i_serial_din),
        .o_busy(rx_busy_w),
        .o_done(rx_done_w),
        .o_sclk(rx_clk_w),
        .o_dout(),
        .o_data(rx_shift_buffer)
    );

    pios_shifter u_tx
    (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_start(tx_start_w && !tx_busy_w),
        .i_slow(slow_w),
        .i_is_tx(1'b1),
        .i_load({i_wdata, i_accumulator}),
        .i_din(1'b0),
        .o_busy(tx_busy_w),
        .o_done(tx_done_w),
        .o_sclk(tx_clk_w),
        .o_dout(tx_dout_w),
        .o_data()
    );

    // ------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            port_c_pin_ff <= `PIOS_NIB_ZERO;
            port_c_oe_ff <= `PIOS_NIB_ZERO;
            port_d_pin_ff <= `PIOS_NIB_ZERO;
            port_d_oe_ff <= `PIOS_NIB_ZERO;
            led_ff <= `PIOS_NIB_ZERO;
            pullup_ff <= 1'b0;
            port_c_in_ff <= `PIOS_NIB_ZERO;
            port_d_in_ff <= `PIOS_NIB_ZERO;
            event_flags_ff <= 8'h00;
        end
        else if (i_ce)
        begin
            port_c_pin_ff <= port_c_out_ff;
            port_c_oe_ff <= c_oe_w;
            port_d_pin_ff <= port_d_out_ff;
            port_d_oe_ff <= d_oe_w;
            led_ff <= led_w;
            pullup_ff <= serial_mode_w;
            port_c_in_ff <= c_level_w;
            port_d_in_ff <= d_level_w;
            event_flags_ff <= event_w;
        end
    end

    assign o_port_c = port_c_pin_ff;
    assign o_port_c_oe = port_c_oe_ff;
    assign o_port_d = port_d_pin_ff;
    assign o_port_d_oe = port_d_oe_ff;
    assign o_led_output_port = led_ff;
    assign o_serial_din_pullup = pullup_ff;
    assign o_port_c_in = port_c_in_ff;
    assign o_port_d_in = port_d_in_ff;
    assign o_change_detect_status = change_detect_status_ff;
    assign o_serial_busy_status = {busy_w[3], 1'b0, busy_w[1], 1'b0};
    assign o_rx_accumulator = rx_acc_ff;
    assign o_rx_ram = rx_ram_ff;
    assign o_event_flags = event_flags_ff;
    assign o_stop_wake = stop_wake_ff;
endmodule // pios_top
`default_nettype wire

// file: tb/pios_top_properties.sv
// concurrent checks on the pins of the port and serial shift block
`timescale 1ns/1ps
`default_nettype none
module pios_chk
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // instruction strobes
    input wire logic i_wr_port_c_direction,
    input wire logic i_receive_instruction,
    input wire logic i_transmit_instruction,
    input wire logic i_change_int_accept,
    input wire logic [3:0] i_wdata,
    // block outputs
    input wire logic [3:0] o_port_c_oe,
    input wire logic [3:0] o_port_d_oe,
    input wire logic [3:0] o_led_output_port,
    input wire logic o_serial_din_pullup,
    input wire logic [3:0] o_change_detect_status,
    input wire logic [3:0] o_serial_busy_status,
    input wire logic [7:0] o_event_flags
);
    default clocking dc @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    logic [3:0] rx_n_ff;
    logic [3:0] tx_n_ff;
    logic [3:0] led_ff;
    logic pu_ff;
    logic rx_act_ff;
    logic tx_act_ff;
    // rising serial clock edges seen in settled serial mode; cleared once the done event has been judged
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_n_ff <= 4'h0;
            tx_n_ff <= 4'h0;
            led_ff <= 4'hF;
            pu_ff <= 1'b0;
            rx_act_ff <= 1'b0;
            tx_act_ff <= 1'b0;
        end
        else
        begin
            led_ff <= o_led_output_port;
            pu_ff <= o_serial_din_pullup;
            if (o_event_flags[5])
                rx_n_ff <= 4'h0;
            else if (o_led_output_port[3] && !led_ff[3] && o_serial_din_pullup && pu_ff)
                rx_n_ff <= rx_n_ff + 4'h1;
            if (o_event_flags[6])
                tx_n_ff <= 4'h0;
            else if (o_led_output_port[1] && !led_ff[1] && o_serial_din_pullup && pu_ff)
                tx_n_ff <= tx_n_ff + 4'h1;
            // a transfer runs from its instruction to its done event, whatever the busy flags say
            if (o_event_flags[5])
                rx_act_ff <= 1'b0;
            else if (i_receive_instruction && o_serial_din_pullup)
                rx_act_ff <= 1'b1;
            if (o_event_flags[6])
                tx_act_ff <= 1'b0;
            else if (i_transmit_instruction && o_serial_din_pullup)
                tx_act_ff <= 1'b1;
        end
    end
    property p_dir_c;
        i_wr_port_c_direction ##1 !i_wr_port_c_direction |-> ##1 o_port_c_oe == ~$past(i_wdata, 2);
    endproperty
    a_dir_c: assert property (p_dir_c) else $error("port c drive enable wrong");
    property p_dir_rst;
        $rose(i_rst_n) |-> o_port_c_oe == 4'h0 && o_port_d_oe == 4'h0;
    endproperty
    a_dir_rst: assert property (p_dir_rst) else $error("port driven out of reset");
    property p_rx_busy;
        i_receive_instruction && o_serial_din_pullup && !o_serial_busy_status[1] |-> ##[1:2] o_serial_busy_status[1];
    endproperty
    a_rx_busy: assert property (p_rx_busy) else $error("rx busy not set");
    property p_rx_done;
        $fell(o_serial_busy_status[1]) |-> ##[0:1] o_event_flags[5];
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx done event missing");
    property p_rx_cnt;
        o_event_flags[5] |-> rx_n_ff == 4'h8;
    endproperty
    a_rx_cnt: assert property (p_rx_cnt) else $error("rx clock count wrong");
    property p_tx_cnt;
        o_event_flags[6] |-> tx_n_ff == 4'h8 && !o_serial_busy_status[3];
    endproperty
    a_tx_cnt: assert property (p_tx_cnt) else $error("tx clock count wrong");
    property p_idle;
        o_serial_din_pullup && pu_ff && !rx_act_ff && !tx_act_ff
            |-> o_led_output_port[3] && o_led_output_port[1];
    endproperty
    a_idle: assert property (p_idle) else $error("serial clock not idle high");
    property p_keep;
        i_change_int_accept |=>
            (o_change_detect_status & $past(o_change_detect_status)) == $past(o_change_detect_status);
    endproperty
    a_keep: assert property (p_keep) else $error("change status lost on accept");
endmodule // pios_chk
`default_nettype wire

// file: tb/pios_peer.sv
// serial peer: sends a byte on the rx clock and captures the tx byte
`timescale 1ns/1ps
`default_nettype none
module pios_peer
(
    // serial pins
    input wire logic i_rx_clock,
    input wire logic i_tx_clock,
    input wire logic i_tx_data,
    output logic o_rx_data,
    // byte exchange
    input wire logic i_arm,
    input wire logic [7:0] i_send,
    output logic [7:0] o_got
);
    logic [7:0] sh_ff;
    initial o_rx_data = 1'b1;
    always @(posedge i_arm)
        sh_ff = i_send;
    // next bit goes out on the fall, a full low phase before the sampling rise
    always @(negedge i_rx_clock)
    begin
        o_rx_data <= sh_ff[0];
        sh_ff = {1'b1, sh_ff[7:1]};
    end
    // bit is spent once sampled; the line falls back to its pull-up level
    always @(posedge i_rx_clock)
        o_rx_data <= 1'b1;
    always @(posedge i_tx_clock)
        o_got <= {i_tx_data, o_got[7:1]};
endmodule // pios_peer
`default_nettype wire

// file: tb/port_io_serial_shift_test.sv
// self-checking bench for the port and serial shift block
`timescale 1ns/1ps
`default_nettype none
module port_io_serial_shift_test;
    localparam int CD = 0, DD = 1, EN = 2, MD = 3, SW = 4, CDAT = 5, DDAT = 6, LAT = 7;
    localparam int CLR = 8, RX = 9, TX = 10, ACC = 11, CBS = 12;
    logic i_clock, i_rst_n, i_serial_din, o_serial_din_pullup, o_stop_wake, arm, w;
    logic [12:0] st;
    logic [3:0] i_wdata, i_accumulator, i_port_c, i_port_d, o_port_c, o_port_c_oe, o_port_d, o_port_d_oe;
    logic [3:0] o_led_output_port, o_port_c_in, o_port_d_in, o_change_detect_status, o_serial_busy_status;
    logic [3:0] o_rx_accumulator, o_rx_ram;
    logic [7:0] o_event_flags, send, got;
    // high nibble is the direction written, low nibble the drive enable it should give
    logic [7:0] rows [4] = '{8'hF0, 8'h0F, 8'hA5, 8'h5A};
    int err_count, checks, cyc;
    pios_top pios_top_inst
    (
        .i_clock, .i_rst_n, .i_ce(1'b1), .i_wr_port_c_direction(st[CD]), .i_wr_port_d_direction(st[DD]),
        .i_wr_change_detect_enable(st[EN]), .i_wr_output_port_mode(st[MD]), .i_wr_stop_wake_enable(st[SW]),
        .i_wr_port_c_data(st[CDAT]), .i_wr_port_d_data(st[DDAT]), .i_wr_parallel_latch(st[LAT]),
        .i_clear_change_status_instr(st[CLR]), .i_clear_busy_status(st[CBS]), .i_receive_instruction(st[RX]),
        .i_transmit_instruction(st[TX]), .i_wdata, .i_accumulator, .i_change_int_accept(st[ACC]), .i_port_c,
        .i_port_d, .i_serial_din, .o_port_c, .o_port_c_oe, .o_port_d, .o_port_d_oe, .o_led_output_port,
        .o_serial_din_pullup, .o_port_c_in, .o_port_d_in, .o_change_detect_status, .o_serial_busy_status,
        .o_rx_accumulator, .o_rx_ram, .o_event_flags, .o_stop_wake
    );
    pios_peer pios_peer_inst
    (
        .i_rx_clock(o_led_output_port[3]), .i_tx_clock(o_led_output_port[1]), .i_tx_data(o_led_output_port[0]),
        .o_rx_data(i_serial_din), .i_arm(arm), .i_send(send), .o_got(got)
    );
    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    // the whole run needs about 2200 cycles
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic op(input int k, input logic [3:0] d);
        @(negedge i_clock);
        st[k] = 1'b1;
        i_wdata = d;
        @(negedge i_clock);
        st[k] = 1'b0;
    endtask
    task automatic ev(input int b);
        w = 1'b0;
        repeat (3000)
        begin
            @(negedge i_clock);
            w = o_event_flags[b];
            if (w === 1'b1)
                break;
        end
        chk("done event", {7'h00, w}, 8'h01);
    endtask
    task automatic print_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        st = 13'h0000;
        i_wdata = 4'h0;
        i_accumulator = 4'h0;
        i_port_c = 4'h0;
        i_port_d = 4'h9;
        arm = 1'b0;
        send = 8'h3C;
        i_rst_n = 1'b0;
        repeat (8) @(negedge i_clock);
        chk("oe c reset", o_port_c_oe, 8'h00);
        chk("oe d reset", o_port_d_oe, 8'h00);
        i_rst_n = 1'b1;
        foreach (rows[i])
        begin
            op(CD, rows[i][7:4]);
            op(DD, rows[i][7:4]);
            @(negedge i_clock);
            chk("oe c", o_port_c_oe, rows[i][3:0]);
            chk("oe d", o_port_d_oe, rows[i][3:0]);
        end
        op(CDAT, 4'hF);
        op(DDAT, 4'hF);
        @(negedge i_clock);
        chk("c drive", o_port_c & o_port_c_oe, 8'h0A);
        chk("d drive", o_port_d & o_port_d_oe, 8'h0A);
        chk("d read", o_port_d_in & 4'h5, 8'h01);
        // driven value matched to the pin level before the pins turn to inputs
        op(CDAT, 4'h0);
        op(CD, 4'hF);
        op(EN, 4'hF);
        op(CLR, 4'h0);
        op(ACC, 4'h0);
        i_port_c = 4'h4;
        repeat (4) @(negedge i_clock);
        chk("status", o_change_detect_status, 8'h04);
        chk("c read", o_port_c_in, 8'h04);
        chk("event", o_event_flags[2], 8'h01);
        op(ACC, 4'h0);
        @(negedge i_clock);
        chk("event accepted", o_event_flags[2], 8'h00);
        chk("status kept", o_change_detect_status, 8'h04);
        op(EN, 4'h3);
        @(negedge i_clock);
        chk("status enable write", o_change_detect_status, 8'h00);
        i_port_c = 4'hC;
        repeat (4) @(negedge i_clock);
        chk("masked", o_event_flags[2], 8'h00);
        op(SW, 4'h8);
        i_port_c = 4'h4;
        w = 1'b0;
        repeat (4)
        begin
            @(negedge i_clock);
            w = w | o_stop_wake;
        end
        chk("wake", {7'h00, w}, 8'h01);
        op(LAT, 4'h6);
        op(TX, 4'h0);
        @(negedge i_clock);
        chk("latch", o_led_output_port, 8'h06);
        chk("refused", o_serial_busy_status, 8'h00);
        op(MD, 4'h2);
        @(negedge i_clock);
        chk("idle", o_led_output_port & 4'hA, 8'h0A);
        chk("pullup", o_serial_din_pullup, 8'h01);
        i_accumulator = 4'h5;
        op(TX, 4'hA);
        @(negedge i_clock);
        chk("tx busy", o_serial_busy_status, 8'h08);
        ev(6);
        chk("tx idle", o_serial_busy_status, 8'h00);
        chk("tx byte", got, 8'hA5);
        arm = 1'b1;
        op(RX, 4'h0);
        arm = 1'b0;
        @(negedge i_clock);
        chk("rx busy", o_serial_busy_status, 8'h02);
        ev(5);
        chk("rx idle", o_serial_busy_status, 8'h00);
        op(RX, 4'h0);
        @(negedge i_clock);
        chk("rx byte", {o_rx_ram, o_rx_accumulator}, 8'h3C);
        ev(5);
        op(MD, 4'hA);
        op(TX, 4'h1);
        repeat (600) @(negedge i_clock);
        chk("slow busy", o_serial_busy_status, 8'h08);
        op(CBS, 4'h0);
        @(negedge i_clock);
        chk("busy cleared", o_serial_busy_status, 8'h00);
        ev(6);
        chk("slow byte", got, 8'h15);
        // second reset in mid-run: ports back to inputs, latch output low
        i_rst_n = 1'b0;
        @(negedge i_clock);
        chk("oe c mid reset", o_port_c_oe, 8'h00);
        chk("busy mid reset", o_serial_busy_status, 8'h00);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clock);
        chk("oe d after reset", o_port_d_oe, 8'h00);
        chk("led after reset", o_led_output_port, 8'h00);
        print_verdict();
    end
endmodule // port_io_serial_shift_test
bind pios_top pios_chk pios_chk_inst
(
    .i_clock, .i_rst_n, .i_wr_port_c_direction, .i_receive_instruction, .i_transmit_instruction,
    .i_change_int_accept, .i_wdata, .o_port_c_oe, .o_port_d_oe, .o_led_output_port,
    .o_serial_din_pullup, .o_change_detect_status, .o_serial_busy_status, .o_event_flags
);
`default_nettype wire
